// *** hw/rf_sleep_power_defines.svh ***
// Constants for the radio power, clear channel and sleep control block
`ifndef RF_SLEEP_POWER_DEFINES_SVH
`define RF_SLEEP_POWER_DEFINES_SVH

// Parameter select codes on the configuration port
`define PAR_TX_POWER_LEVEL 3'h0
`define PAR_BOOST_SELECT 3'h1
`define PAR_CLEAR_CHANNEL_LIMIT 3'h2
`define PAR_SLEEP_KIND 3'h3
`define PAR_WAKE_DURATION 3'h4
`define PAR_CYCLIC_SLEEP_PERIOD 3'h5
`define PAR_UNJOINED_SLEEP_PERIOD 3'h6
`define PAR_SLEEP_OPTION_BITS 3'h7

// Reset values
`define RST_TX_POWER_LEVEL 3'h4
`define RST_BOOST_SELECT 1'h1
`define RST_CLEAR_CHANNEL_LIMIT 8'h2c
`define RST_SLEEP_KIND 3'h0
`define RST_WAKE_DURATION 16'h1388
`define RST_CYCLIC_SLEEP_PERIOD 21'h000000
`define RST_UNJOINED_SLEEP_PERIOD 16'h03e8
`define RST_SLEEP_OPTION_BITS 2'h0

// Accepted ranges
`define MAX_TX_POWER_LEVEL 21'h000004
`define MIN_CLEAR_CHANNEL_LIMIT 21'h000028
`define MAX_CLEAR_CHANNEL_LIMIT 21'h000050
`define MAX_CYCLIC_SLEEP_PERIOD 21'h15f900
`define MAX_SLEEP_OPTION_BITS 21'h000003

// Sleep kind codes
`define SLEEP_NONE 3'h0
`define SLEEP_PIN 3'h1
`define SLEEP_CYCLIC 3'h4
`define SLEEP_CYCLIC_PIN 3'h5

// Option bit positions
`define OPT_NO_POLL 0
`define OPT_NO_SAMPLE 1

// Power cap in dBm and boost gains in dB
`define TOP_CHANNEL_CAP_DBM 6'sh3b
`define BOOST_TX_GAIN_DB 6'h03
`define BOOST_RX_GAIN_DB 6'h02

// Timing
`define CLK_PERIOD_NS 20
`define MS_NS 1000000
`define MS_CYCLES (`MS_NS / `CLK_PERIOD_NS)
`define RECAL_S 15
`define RECAL_CYCLES (`RECAL_S * 1000 * `MS_CYCLES)
`define PERIOD_UNIT_MS 10
`define HOLD_UNIT_MS 25

`endif

// *** hw/rf_sleep_power_pkg.sv ***
// Types shared by the radio power and sleep control block
package rf_sleep_power_pkg;

  typedef enum logic [3:0] {
    ST_AWAKE = 4'b0001,
    ST_PIN_SLEEP = 4'b0010,
    ST_CYC_WAKE = 4'b0100,
    ST_CYC_SLEEP = 4'b1000
  } sleep_state_t;

  typedef logic [2:0] param_sel_t;
  typedef logic [20:0] param_word_t;

endpackage

// *** hw/rf_sleep_power_control.sv ***
// Radio power, clear channel gate and sleep scheduling control
`timescale 1ns/10ps
`include "rf_sleep_power_defines.svh"

module rf_sleep_power_control #(
  parameter int MS_CYCLES = `MS_CYCLES,
  parameter int RECAL_CYCLES = `RECAL_CYCLES,
  parameter bit HIGH_POWER = 1'b0
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Configuration command port
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire rf_sleep_power_pkg::param_sel_t cmd_param_i,
  input wire rf_sleep_power_pkg::param_word_t cmd_data_i,
  output logic rsp_valid_o,
  output logic rsp_error_o,
  output rf_sleep_power_pkg::param_word_t rsp_data_o,
  // Transmit path
  input wire logic top_channel_i,
  input wire logic signed [5:0] cal_offset_i,
  input wire logic tx_req_i,
  input wire logic [7:0] energy_i,
  output logic tx_grant_o,
  output logic tx_blocked_o,
  output logic signed [5:0] tx_power_dbm_o,
  output logic [5:0] rx_gain_db_o,
  output logic recal_o,
  // Network role and sleep
  input wire logic coordinator_i,
  input wire logic associate_en_i,
  input wire logic associated_i,
  input wire logic sleep_pin_i,
  input wire logic data_pending_i,
  input wire logic sample_en_i,
  input wire logic msg_hold_i,
  output logic asleep_o,
  output logic poll_o,
  output logic sample_o,
  output logic assoc_retry_o,
  output logic direct_send_o,
  output logic msg_discard_o
);
  import rf_sleep_power_pkg::*;

  // Counters below cannot time a span shorter than one clock
  if (MS_CYCLES < 1 || RECAL_CYCLES < 1) begin : g_bad_timing
    $error("timing counts must be at least one cycle");
  end

  logic [2:0] tx_power_level_reg;
  logic boost_select_reg;
  logic [7:0] clear_channel_limit_reg;
  logic [2:0] sleep_kind_reg;
  logic [15:0] wake_duration_reg;
  logic [20:0] cyclic_sleep_period_reg;
  logic [15:0] unjoined_sleep_period_reg;
  logic [1:0] sleep_option_bits_reg;

  // Range check of an incoming write value
  logic wr_ok;
  always_comb begin
    case (cmd_param_i)
      `PAR_TX_POWER_LEVEL: wr_ok = cmd_data_i <= `MAX_TX_POWER_LEVEL;
      `PAR_BOOST_SELECT: wr_ok = cmd_data_i <= 21'h000001;
      `PAR_CLEAR_CHANNEL_LIMIT: wr_ok =
        cmd_data_i >= `MIN_CLEAR_CHANNEL_LIMIT &&
        cmd_data_i <= `MAX_CLEAR_CHANNEL_LIMIT;
      `PAR_SLEEP_KIND: wr_ok = cmd_data_i == 21'h000000 ||
        cmd_data_i == 21'h000001 || cmd_data_i == 21'h000004 ||
        cmd_data_i == 21'h000005;
      `PAR_WAKE_DURATION,
      `PAR_UNJOINED_SLEEP_PERIOD: wr_ok = cmd_data_i != 21'h000000 &&
        cmd_data_i <= 21'h00ffff;
      `PAR_CYCLIC_SLEEP_PERIOD: wr_ok =
        cmd_data_i <= `MAX_CYCLIC_SLEEP_PERIOD;
      `PAR_SLEEP_OPTION_BITS: wr_ok = cmd_data_i <= `MAX_SLEEP_OPTION_BITS;
      default: wr_ok = 1'b0;
    endcase
  end

  logic do_write;
  assign do_write = cmd_valid_i && cmd_write_i && wr_ok;

  // Configuration storage; out of range writes leave the value alone
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_power_level_reg <= `RST_TX_POWER_LEVEL;
      boost_select_reg <= `RST_BOOST_SELECT;
      clear_channel_limit_reg <= `RST_CLEAR_CHANNEL_LIMIT;
      sleep_kind_reg <= `RST_SLEEP_KIND;
      wake_duration_reg <= `RST_WAKE_DURATION;
      cyclic_sleep_period_reg <= `RST_CYCLIC_SLEEP_PERIOD;
      unjoined_sleep_period_reg <= `RST_UNJOINED_SLEEP_PERIOD;
      sleep_option_bits_reg <= `RST_SLEEP_OPTION_BITS;
    end else if (do_write) begin
      case (cmd_param_i)
        `PAR_TX_POWER_LEVEL: tx_power_level_reg <= cmd_data_i[2:0];
        `PAR_BOOST_SELECT: boost_select_reg <= cmd_data_i[0];
        `PAR_CLEAR_CHANNEL_LIMIT: clear_channel_limit_reg <= cmd_data_i[7:0];
        `PAR_SLEEP_KIND: sleep_kind_reg <= cmd_data_i[2:0];
        `PAR_WAKE_DURATION: wake_duration_reg <= cmd_data_i[15:0];
        `PAR_CYCLIC_SLEEP_PERIOD: cyclic_sleep_period_reg <= cmd_data_i;
        `PAR_UNJOINED_SLEEP_PERIOD:
          unjoined_sleep_period_reg <= cmd_data_i[15:0];
        `PAR_SLEEP_OPTION_BITS: sleep_option_bits_reg <= cmd_data_i[1:0];
        default: tx_power_level_reg <= tx_power_level_reg;
      endcase
    end
  end

  // Answer one cycle after every command; a write echoes the value held before it
  param_word_t rd_value;
  always_comb begin
    case (cmd_param_i)
      `PAR_TX_POWER_LEVEL: rd_value = {18'h0, tx_power_level_reg};
      `PAR_BOOST_SELECT: rd_value = {20'h0, boost_select_reg};
      `PAR_CLEAR_CHANNEL_LIMIT: rd_value = {13'h0, clear_channel_limit_reg};
      `PAR_SLEEP_KIND: rd_value = {18'h0, sleep_kind_reg};
      `PAR_WAKE_DURATION: rd_value = {5'h0, wake_duration_reg};
      `PAR_CYCLIC_SLEEP_PERIOD: rd_value = cyclic_sleep_period_reg;
      `PAR_UNJOINED_SLEEP_PERIOD: rd_value = {5'h0, unjoined_sleep_period_reg};
      `PAR_SLEEP_OPTION_BITS: rd_value = {19'h0, sleep_option_bits_reg};
      default: rd_value = 21'h000000;
    endcase
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rsp_valid_o <= 1'b0;
      rsp_error_o <= 1'b0;
      rsp_data_o <= 21'h000000;
    end else begin
      rsp_valid_o <= cmd_valid_i;
      rsp_error_o <= cmd_valid_i && cmd_write_i && !wr_ok;
      rsp_data_o <= cmd_valid_i ? rd_value : 21'h000000;
    end
  end

  // Recalibration interval for the high-power variant
  logic [31:0] recal_cnt_reg;
  logic signed [5:0] cal_trim_reg;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      recal_cnt_reg <= 32'h00000000;
      recal_o <= 1'b0;
      cal_trim_reg <= 6'sh00;
    end else begin
      recal_o <= 1'b0;
      if (!HIGH_POWER) begin
        recal_cnt_reg <= 32'h00000000;
      end else if (recal_cnt_reg == 32'(RECAL_CYCLES - 1)) begin
        recal_cnt_reg <= 32'h00000000;
        recal_o <= 1'b1;
        cal_trim_reg <= cal_offset_i;
      end else begin
        recal_cnt_reg <= recal_cnt_reg + 32'h00000001;
      end
    end
  end

  // Output power lookup, applied to the next transmission
  logic signed [5:0] power_next;
  always_comb begin
    if (HIGH_POWER) begin
      case (tx_power_level_reg)
        3'h0: power_next = 6'sh00;
        3'h1: power_next = 6'sh0c;
        3'h2: power_next = 6'sh0f;
        3'h3: power_next = 6'sh10;
        default: power_next = 6'sh12;
      endcase
      power_next = power_next + cal_trim_reg;
    end else if (top_channel_i) begin
      // Level ignored on the top channel to honour the emission cap
      power_next = boost_select_reg ? `TOP_CHANNEL_CAP_DBM :
        6'(`TOP_CHANNEL_CAP_DBM - `BOOST_TX_GAIN_DB);
    end else begin
      // Level steps are uneven, so a table rather than a formula
      case (tx_power_level_reg)
        3'h0: power_next = 6'sh3b;
        3'h1: power_next = 6'sh3f;
        3'h2: power_next = 6'sh01;
        3'h3: power_next = 6'sh03;
        default: power_next = 6'sh05;
      endcase
      if (boost_select_reg) begin
        power_next = power_next + `BOOST_TX_GAIN_DB;
      end
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_power_dbm_o <= 6'sh00;
      rx_gain_db_o <= 6'h00;
      tx_grant_o <= 1'b0;
      tx_blocked_o <= 1'b0;
    end else begin
      tx_power_dbm_o <= power_next;
      rx_gain_db_o <= boost_select_reg ? `BOOST_RX_GAIN_DB : 6'h00;
      // Smaller magnitude means stronger energy in -dBm units
      tx_grant_o <= tx_req_i && energy_i >= clear_channel_limit_reg;
      tx_blocked_o <= tx_req_i && energy_i < clear_channel_limit_reg;
    end
  end

  // Millisecond tick shared by all sleep timers
  logic [31:0] ms_cnt_reg;
  logic ms_tick;
  assign ms_tick = ms_cnt_reg == 32'(MS_CYCLES - 1);
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ms_cnt_reg <= 32'h00000000;
    end else begin
      ms_cnt_reg <= ms_tick ? 32'h00000000 : ms_cnt_reg + 32'h00000001;
    end
  end

  // Sleep sequencing
  sleep_state_t state_reg;
  logic [26:0] tmr_reg;
  logic cyclic;
  logic unjoined;
  assign cyclic = !coordinator_i &&
    (sleep_kind_reg == `SLEEP_CYCLIC || sleep_kind_reg == `SLEEP_CYCLIC_PIN);
  assign unjoined = associate_en_i && !associated_i;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= ST_AWAKE;
      tmr_reg <= 27'h0000000;
      asleep_o <= 1'b0;
      poll_o <= 1'b0;
      sample_o <= 1'b0;
      assoc_retry_o <= 1'b0;
    end else begin
      poll_o <= 1'b0;
      sample_o <= 1'b0;
      assoc_retry_o <= 1'b0;
      case (state_reg)
        ST_AWAKE: begin
          asleep_o <= 1'b0;
          tmr_reg <= 27'(wake_duration_reg);
          if (sleep_kind_reg == `SLEEP_PIN && sleep_pin_i) begin
            state_reg <= ST_PIN_SLEEP;
            asleep_o <= 1'b1;
          end else if (cyclic) begin
            state_reg <= ST_CYC_WAKE;
          end
        end
        ST_PIN_SLEEP: begin
          if (sleep_kind_reg != `SLEEP_PIN || !sleep_pin_i) begin
            state_reg <= ST_AWAKE;
            asleep_o <= 1'b0;
            sample_o <= sample_en_i &&
              !sleep_option_bits_reg[`OPT_NO_SAMPLE];
          end
        end
        ST_CYC_WAKE: begin
          if (!cyclic) begin
            state_reg <= ST_AWAKE;
          end else if (data_pending_i) begin
            tmr_reg <= 27'(wake_duration_reg);
          end else if (ms_tick && tmr_reg <= 27'h0000001) begin
            // Sleep length is taken fresh each cycle
            state_reg <= ST_CYC_SLEEP;
            asleep_o <= 1'b1;
            tmr_reg <= unjoined ?
              27'(unjoined_sleep_period_reg * 27'(`PERIOD_UNIT_MS)) :
              27'(cyclic_sleep_period_reg * 27'(`PERIOD_UNIT_MS));
          end else if (ms_tick) begin
            tmr_reg <= tmr_reg - 27'h0000001;
          end
        end
        ST_CYC_SLEEP: begin
          if (!cyclic ||
              (sleep_kind_reg == `SLEEP_CYCLIC_PIN && sleep_pin_i) ||
              tmr_reg == 27'h0000000 ||
              (ms_tick && tmr_reg == 27'h0000001)) begin
            state_reg <= cyclic ? ST_CYC_WAKE : ST_AWAKE;
            asleep_o <= 1'b0;
            tmr_reg <= 27'(wake_duration_reg);
            poll_o <= cyclic && !unjoined &&
              !sleep_option_bits_reg[`OPT_NO_POLL];
            assoc_retry_o <= cyclic && unjoined;
            sample_o <= sample_en_i &&
              !sleep_option_bits_reg[`OPT_NO_SAMPLE];
          end else if (ms_tick) begin
            tmr_reg <= tmr_reg - 27'h0000001;
          end
        end
        default: begin
          state_reg <= ST_AWAKE;
          asleep_o <= 1'b0;
        end
      endcase
    end
  end

  // Coordinator hold of one indirect message, 2.5 sleep periods long
  logic hold_busy_reg;
  logic [26:0] hold_tmr_reg;
  logic hold_mode;
  assign hold_mode = coordinator_i && cyclic_sleep_period_reg != 21'h000000;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hold_busy_reg <= 1'b0;
      hold_tmr_reg <= 27'h0000000;
      msg_discard_o <= 1'b0;
      direct_send_o <= 1'b0;
    end else begin
      msg_discard_o <= 1'b0;
      direct_send_o <= coordinator_i && !hold_mode;
      if (msg_hold_i && hold_mode) begin
        hold_busy_reg <= 1'b1;
        hold_tmr_reg <= 27'(cyclic_sleep_period_reg *
          27'(`HOLD_UNIT_MS));
      end else if (hold_busy_reg && !hold_mode) begin
        hold_busy_reg <= 1'b0;
      end else if (hold_busy_reg && ms_tick) begin
        if (hold_tmr_reg <= 27'h0000001) begin
          hold_busy_reg <= 1'b0;
          msg_discard_o <= 1'b1;
        end else begin
          hold_tmr_reg <= hold_tmr_reg - 27'h0000001;
        end
      end
    end
  end

endmodule

// *** test/rf_sleep_power_control_assertions.sv ***
// Port-level properties of the radio power and sleep control block
`timescale 1ns/10ps
module rf_sleep_power_control_assertions (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Watched inputs
  input wire logic cmd_valid_i,
  input wire logic tx_req_i,
  input wire logic top_channel_i,
  input wire logic coordinator_i,
  // Watched outputs
  input wire logic rsp_valid_o,
  input wire logic rsp_error_o,
  input wire rf_sleep_power_pkg::param_word_t rsp_data_o,
  input wire logic tx_grant_o,
  input wire logic tx_blocked_o,
  input wire logic signed [5:0] tx_power_dbm_o,
  input wire logic [5:0] rx_gain_db_o,
  input wire logic poll_o,
  input wire logic assoc_retry_o,
  input wire logic direct_send_o,
  input wire logic msg_discard_o
);
  import rf_sleep_power_pkg::*;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  chk_rsp_follows: assert property (cmd_valid_i |=> rsp_valid_o)
    else $error("No response one cycle after a command");
  chk_rsp_quiet: assert property
    (!cmd_valid_i |=> !rsp_valid_o && rsp_data_o == 21'h0)
    else $error("Response without a command");
  chk_err_framed: assert property (rsp_error_o |-> rsp_valid_o)
    else $error("Error flag outside a response");
  chk_tx_answer: assert property
    (tx_req_i |=> tx_grant_o != tx_blocked_o)
    else $error("Request not answered by exactly one verdict");
  chk_tx_quiet: assert property
    (!tx_req_i |=> !(tx_grant_o || tx_blocked_o))
    else $error("Verdict without a request");
  chk_top_cap: assert property
    (top_channel_i [*2] |-> tx_power_dbm_o <= -6'sd5)
    else $error("Top channel power above cap");
  chk_gain_step: assert property
    (rx_gain_db_o != 6'h00 |-> rx_gain_db_o == 6'h02)
    else $error("Receive gain not 0 or 2");
  chk_direct_cause: assert property
    (direct_send_o |-> $past(coordinator_i))
    else $error("Direct send without coordinator role");
  chk_discard_held: assert property
    (msg_discard_o |-> !direct_send_o)
    else $error("Discard while sending directly");
  chk_retry_no_poll: assert property
    (assoc_retry_o |-> !poll_o)
    else $error("Poll during association retry");
endmodule

bind rf_sleep_power_control rf_sleep_power_control_assertions i_chk (
  .clock_i, .arst_n_i, .cmd_valid_i, .tx_req_i, .top_channel_i,
  .coordinator_i, .rsp_valid_o, .rsp_error_o, .rsp_data_o, .tx_grant_o,
  .tx_blocked_o, .tx_power_dbm_o, .rx_gain_db_o, .poll_o,
  .assoc_retry_o, .direct_send_o, .msg_discard_o);

// *** test/host_cmd_model.sv ***
// Host model issuing configuration commands
`timescale 1ns/10ps
module host_cmd_model (
  // Clock
  input wire logic clock_i,
  // Command port
  output logic cmd_valid_o,
  output logic cmd_write_o,
  output rf_sleep_power_pkg::param_sel_t cmd_param_o,
  output rf_sleep_power_pkg::param_word_t cmd_data_o,
  // Response
  input wire logic rsp_valid_i,
  input wire logic rsp_error_i,
  input wire rf_sleep_power_pkg::param_word_t rsp_data_i
);
  import rf_sleep_power_pkg::*;
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_param_o = 3'h0;
    cmd_data_o = 21'h0;
  end
  // Held through the taking edge; answer read one cycle later
  task automatic xfer(input logic w, input param_sel_t p,
      input param_word_t d, output logic ok, output logic err,
      output param_word_t q);
    @(posedge clock_i);
    cmd_valid_o <= 1'b1;
    cmd_write_o <= w;
    cmd_param_o <= p;
    cmd_data_o <= d;
    @(posedge clock_i);
    // Released lines must not keep showing the last value
    cmd_valid_o <= 1'b0;
    cmd_write_o <= ~w;
    cmd_param_o <= ~p;
    cmd_data_o <= ~d;
    @(posedge clock_i);
    ok = rsp_valid_i;
    err = rsp_error_i;
    q = rsp_data_i;
  endtask
endmodule

// *** test/testbench.sv ***
// Self-checking bench for the radio power and sleep control block
`timescale 1ns/10ps
`include "rf_sleep_power_defines.svh"
module testbench;
  import rf_sleep_power_pkg::*;
  logic clock_i, arst_n_i, cmd_valid_i, cmd_write_i, rsp_valid_o;
  logic rsp_error_o, top_channel_i, tx_req_i, tx_grant_o, tx_blocked_o;
  logic recal_o, coordinator_i, associate_en_i, associated_i, sleep_pin_i;
  logic sample_en_i, msg_hold_i, asleep_o, poll_o, sample_o, ok, er;
  logic assoc_retry_o, direct_send_o, msg_discard_o, data_pending_i;
  logic [7:0] energy_i;
  logic signed [5:0] tx_power_dbm_o;
  logic [5:0] rx_gain_db_o;
  param_sel_t cmd_param_i;
  param_word_t cmd_data_i, rsp_data_o, q;
  param_word_t exp_val [8];
  int errors, compares, n_sleep, n_poll, n_samp, n_retry, n_disc, n_recal;
  // Power per level with boost off, in dBm
  int base_dbm [5] = '{-5, -1, 1, 3, 5};

  rf_sleep_power_control #(.MS_CYCLES(4), .RECAL_CYCLES(20),
      .HIGH_POWER(1'b0)) i_dut (
    .clock_i, .arst_n_i, .cmd_valid_i, .cmd_write_i, .cmd_param_i,
    .cmd_data_i, .rsp_valid_o, .rsp_error_o, .rsp_data_o, .top_channel_i,
    .cal_offset_i(6'sh00), .tx_req_i, .energy_i, .tx_grant_o,
    .tx_blocked_o, .tx_power_dbm_o, .rx_gain_db_o, .recal_o,
    .coordinator_i, .associate_en_i, .associated_i, .sleep_pin_i,
    .data_pending_i, .sample_en_i, .msg_hold_i, .asleep_o, .poll_o,
    .sample_o, .assoc_retry_o, .direct_send_o, .msg_discard_o);

  host_cmd_model i_host (.clock_i, .cmd_valid_o(cmd_valid_i),
    .cmd_write_o(cmd_write_i), .cmd_param_o(cmd_param_i),
    .cmd_data_o(cmd_data_i), .rsp_valid_i(rsp_valid_o),
    .rsp_error_i(rsp_error_o), .rsp_data_i(rsp_data_o));

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  task automatic check(input param_word_t got, input param_word_t exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("Compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Write, then read back; a refused write must leave the old value
  task automatic acc(input param_sel_t p, input param_word_t d,
      input logic e);
    i_host.xfer(1'b1, p, d, ok, er, q);
    check(21'(ok), 21'h1);
    check(21'(er), 21'(e));
    check(q, exp_val[p]);
    if (!e) exp_val[p] = d;
    i_host.xfer(1'b0, p, 21'h0, ok, er, q);
    check(q, exp_val[p]);
  endtask

  task automatic tx_try(input logic [7:0] e, input logic blk);
    @(posedge clock_i);
    energy_i <= e;
    tx_req_i <= 1'b1;
    @(posedge clock_i);
    energy_i <= ~e;
    tx_req_i <= 1'b0;
    @(posedge clock_i);
    check(21'(tx_blocked_o), 21'(blk));
    check(21'(tx_grant_o), 21'(!blk));
  endtask

  task automatic watch(input int n);
    {n_sleep, n_poll, n_samp, n_retry, n_disc, n_recal} = '0;
    // First edge lets the latest stimulus reach the outputs
    @(posedge clock_i);
    repeat (n) begin
      @(posedge clock_i);
      n_recal += recal_o;
      n_sleep += asleep_o;
      n_poll += poll_o;
      n_samp += sample_o;
      n_retry += assoc_retry_o;
      n_disc += msg_discard_o;
    end
  endtask

  initial begin
    repeat (60000) @(posedge clock_i);
    errors++;
    final_report();
  end

  initial begin
    {arst_n_i, top_channel_i, tx_req_i, coordinator_i} = '0;
    {associate_en_i, associated_i, sleep_pin_i, sample_en_i} = '0;
    {msg_hold_i, data_pending_i} = '0;
    energy_i = 8'h00;
    exp_val = '{`RST_TX_POWER_LEVEL, `RST_BOOST_SELECT,
      `RST_CLEAR_CHANNEL_LIMIT, `RST_SLEEP_KIND, `RST_WAKE_DURATION,
      `RST_CYCLIC_SLEEP_PERIOD, `RST_UNJOINED_SLEEP_PERIOD,
      `RST_SLEEP_OPTION_BITS};
    repeat (8) @(posedge clock_i);
    arst_n_i <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      i_host.xfer(1'b0, 3'(i), 21'h0, ok, er, q);
      check(q, exp_val[i]);
    end
    acc(`PAR_TX_POWER_LEVEL, 21'h5, 1'b1);
    acc(`PAR_CLEAR_CHANNEL_LIMIT, 21'h27, 1'b1);
    acc(`PAR_CLEAR_CHANNEL_LIMIT, 21'h51, 1'b1);
    acc(`PAR_CLEAR_CHANNEL_LIMIT, 21'h50, 1'b0);
    acc(`PAR_CLEAR_CHANNEL_LIMIT, 21'h28, 1'b0);
    for (int k = 0; k < 8; k++)
      acc(`PAR_SLEEP_KIND, 21'(k), k inside {2, 3, 6, 7});
    acc(`PAR_WAKE_DURATION, 21'h0, 1'b1);
    acc(`PAR_CYCLIC_SLEEP_PERIOD, 21'h15f901, 1'b1);
    acc(`PAR_CYCLIC_SLEEP_PERIOD, 21'h15f900, 1'b0);
    acc(`PAR_UNJOINED_SLEEP_PERIOD, 21'h0, 1'b1);
    acc(`PAR_SLEEP_OPTION_BITS, 21'h4, 1'b1);
    acc(`PAR_CLEAR_CHANNEL_LIMIT, 21'h34, 1'b0);
    tx_try(8'h20, 1'b1);
    tx_try(8'h34, 1'b0);
    tx_try(8'h40, 1'b0);
    for (int l = 0; l < 5; l++) begin
      for (int b = 0; b < 2; b++) begin
        acc(`PAR_TX_POWER_LEVEL, 21'(l), 1'b0);
        acc(`PAR_BOOST_SELECT, 21'(b), 1'b0);
        top_channel_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        check(21'(tx_power_dbm_o), 21'(base_dbm[l] + 3 * b));
        check(21'(rx_gain_db_o), 21'(2 * b));
        top_channel_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        check(21'(tx_power_dbm_o), 21'(b ? -5 : -8));
        top_channel_i <= 1'b0;
      end
    end
    // Same wake time as the coordinator would carry
    acc(`PAR_WAKE_DURATION, 21'h2, 1'b0);
    acc(`PAR_CYCLIC_SLEEP_PERIOD, 21'h1, 1'b0);
    acc(`PAR_UNJOINED_SLEEP_PERIOD, 21'h1, 1'b0);
    acc(`PAR_SLEEP_KIND, `SLEEP_NONE, 1'b0);
    sample_en_i <= 1'b1;
    watch(200);
    check(21'(n_sleep), 21'h0);
    acc(`PAR_SLEEP_KIND, `SLEEP_CYCLIC, 1'b0);
    watch(200);
    check(21'(n_sleep != 0), 21'h1);
    check(21'(n_poll != 0), 21'h1);
    check(21'(n_samp != 0), 21'h1);
    check(21'(n_recal), 21'h0);
    // Pending data keeps the device in its wake phase
    data_pending_i <= 1'b1;
    watch(100);
    check(21'(asleep_o), 21'h0);
    data_pending_i <= 1'b0;
    acc(`PAR_SLEEP_OPTION_BITS, 21'h3, 1'b0);
    watch(200);
    check(21'(n_poll + n_samp), 21'h0);
    acc(`PAR_SLEEP_OPTION_BITS, 21'h0, 1'b0);
    associate_en_i <= 1'b1;
    watch(200);
    check(21'(n_retry != 0), 21'h1);
    check(21'(n_poll), 21'h0);
    associate_en_i <= 1'b0;
    acc(`PAR_SLEEP_KIND, `SLEEP_CYCLIC_PIN, 1'b0);
    watch(100);
    check(21'(n_poll != 0), 21'h1);
    // Pin high cuts every sleep short
    sleep_pin_i <= 1'b1;
    watch(20);
    check(21'(n_poll != 0), 21'h1);
    acc(`PAR_SLEEP_KIND, `SLEEP_PIN, 1'b0);
    sleep_pin_i <= 1'b1;
    watch(5);
    check(21'(n_sleep != 0), 21'h1);
    sleep_pin_i <= 1'b0;
    watch(5);
    check(21'(n_samp != 0), 21'h1);
    check(21'(asleep_o), 21'h0);
    acc(`PAR_SLEEP_KIND, `SLEEP_NONE, 1'b0);
    coordinator_i <= 1'b1;
    acc(`PAR_CYCLIC_SLEEP_PERIOD, 21'h0, 1'b0);
    watch(3);
    check(21'(direct_send_o), 21'h1);
    acc(`PAR_CYCLIC_SLEEP_PERIOD, 21'h2, 1'b0);
    watch(3);
    check(21'(direct_send_o), 21'h0);
    msg_hold_i <= 1'b1;
    @(posedge clock_i);
    msg_hold_i <= 1'b0;
    // Hold is 2.5 periods of 20 ms, about 5 ms of slack before and 10 ms after
    watch(180);
    check(21'(n_disc), 21'h0);
    watch(60);
    check(21'(n_disc), 21'h1);
    final_report();
  end
endmodule
